// ### verilog/cpp_defs.vh
/*
 * Constants of the preset PDO node: register offsets, field positions,
 * reset values, protocol identifiers and timing figures.
 * Assumes inclusion by bare name from the node's design files.
 */
`ifndef CPP_DEFS_VH
`define CPP_DEFS_VH

// Register offsets on the plain register port.
`define CPP_REG_CTRL 4'h0
`define CPP_REG_STAT 4'h4
`define CPP_REG_PRESET 4'h8
`define CPP_REG_TXCNT 4'hc

// Control register fields and reset value.
`define CPP_CTRL_SEND 0
`define CPP_CTRL_INHIBIT 1
`define CPP_CTRL_RST 2'h0

// Status register fields.
`define CPP_STAT_ERR1 0
`define CPP_STAT_ERR2 1
`define CPP_STAT_OPER 2
`define CPP_STAT_BUSY 3
`define CPP_STAT_NODE 8
`define CPP_STAT_SYNC 13
`define CPP_STAT_HIBYTES 14
`define CPP_STAT_SIGN 15
`define CPP_STAT_RATE 16

// Protocol identifiers and command bytes.
`define CPP_ID_NMT 11'h000
`define CPP_ID_SYNC 11'h080
`define CPP_ID_PDO_SYNC 11'h180
`define CPP_ID_PDO_ASYNC 11'h280
`define CPP_NMT_START 8'h01
`define CPP_NMT_STOP 8'h02
`define CPP_NMT_ALL 8'h00
`define CPP_PDO_DLC 4'h8

// Timing: clock period, power-up settle time and LED pattern step.
`define CPP_CLK_NS 10
`define CPP_INIT_NS 1000000
`define CPP_LED_STEP_NS 100000000

`endif

// ### verilog/cpp_bcd2bin.v
/*
 * Six-digit BCD to 32-bit two's-complement converter, one register deep.
 * Assumes digit inputs already synchronised to clk_i.
 */
`timescale 1ns/100ps

module cpp_bcd2bin (
    // Clock and reset.
    input wire clk_i,
    input wire nrst_i,
    // Digits, most significant in bits 23:20, and sign handling.
    input wire [23:0] digits_i,
    input wire sign_mode_i,
    // Converted value.
    output reg [31:0] value_o
);

    reg [31:0] acc;
    reg [3:0] dig;
    reg neg;
    integer i;

    // Horner evaluation; the leading digit becomes a sign when asked.
    always @* begin
        acc = 32'h0;
        dig = 4'h0;
        neg = sign_mode_i && (digits_i[23:20] != 4'h0);
        for (i = 5; i >= 0; i = i - 1) begin
            dig = digits_i[i*4 +: 4];
            if (dig > 4'h9) begin
                dig = 4'h9; // Illegal codes clamp so the range holds.
            end
            if (i == 5 && sign_mode_i) begin
                dig = 4'h0;
            end
            acc = ((acc << 3) + (acc << 1)) + {28'h0, dig};
        end
        if (neg) begin
            acc = (~acc) + 32'h1;
        end
    end

    // Registered result keeps the long adder chain off the output path.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            value_o <= 32'h0;
        end else begin
            value_o <= acc;
        end
    end

endmodule

// ### verilog/cpp_node.v
/*
 * Preset PDO node: straps, NMT start, PDO triggering and framing, error
 * tracking with status LED, bit rate selection and a small register port.
 * Assumes a CAN controller on clk_i that delivers received frames as
 * one-cycle strobes and takes a transmit request held until acknowledged.
 */
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "cpp_defs.vh"

module cpp_node #(
    parameter INIT_CYC = `CPP_INIT_NS / `CPP_CLK_NS,
    parameter LED_STEP_CYC = `CPP_LED_STEP_NS / `CPP_CLK_NS,
    parameter [87:0] RATE_TABLE = {11'd1000, 11'd1000, 11'd500, 11'd250,
                                   11'd125, 11'd50, 11'd20, 11'd10},
    parameter [15:0] LED_PAT_ERR1 = 16'h5555,
    parameter [15:0] LED_PAT_ERR2 = 16'h0505
) (
    // Clock and reset.
    input wire clk_i,
    input wire nrst_i,
    // Switch, thumbwheel and button pins.
    input wire [7:0] dip_addr_i,
    input wire [3:0] dip_rate_i,
    input wire [23:0] thumb_bcd_i,
    input wire enter_i,
    // Received frames from the CAN controller.
    input wire rx_valid_i,
    input wire [10:0] rx_id_i,
    input wire [3:0] rx_dlc_i,
    input wire [63:0] rx_data_i,
    // Transmit request to the CAN controller.
    output reg tx_req_o,
    output reg [10:0] tx_id_o,
    output reg [3:0] tx_dlc_o,
    output reg [63:0] tx_data_o,
    input wire tx_ack_i,
    // Controller error state and bit rate selection.
    input wire err_warn_i,
    input wire err_fatal_i,
    output reg [10:0] bitrate_kbps_o,
    // Front LED.
    output reg led_o,
    // Register port.
    input wire [3:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o
);

    localparam [3:0] ST_INIT = 4'b0001;
    localparam [3:0] ST_PREOP = 4'b0010;
    localparam [3:0] ST_OPER = 4'b0100;
    localparam [3:0] ST_SEND = 4'b1000;
    localparam NPIN = 37;

    // Pick one entry of the bit rate table.
    function [10:0] rate_of;
        input [2:0] sel;
        begin
            rate_of = RATE_TABLE[sel*11 +: 11];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    wire [NPIN-1:0] pin_raw;
    reg [NPIN-1:0] pin_s1_q;
    reg [NPIN-1:0] pin_s2_q;
    assign pin_raw = {enter_i, thumb_bcd_i, dip_rate_i, dip_addr_i};

    // Two flops per pin; only the second stage is read anywhere.
    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : g_sync
            always @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    pin_s1_q[g] <= 1'b0;
                    pin_s2_q[g] <= 1'b0;
                end else begin
                    pin_s1_q[g] <= pin_raw[g];
                    pin_s2_q[g] <= pin_s1_q[g];
                end
            end
        end
    endgenerate

    wire [7:0] dip_addr_s = pin_s2_q[7:0];
    wire [3:0] dip_rate_s = pin_s2_q[11:8];
    wire [23:0] thumb_s = pin_s2_q[35:12];
    wire enter_s = pin_s2_q[36];

    ////////////////////////////////////////////////////////////////////////
    // State, straps and events.

    reg [3:0] state_q;
    reg [31:0] init_cnt_q;
    reg [4:0] node_q;
    reg sync_mode_q;
    reg hi_bytes_q;
    reg sign_mode_q;
    reg [2:0] rate_sel_q;
    reg enter_d1_q;
    reg err1_q;
    reg err2_q;
    reg [1:0] ctrl_q;
    reg soft_send_q;
    reg [31:0] tx_cnt_q;
    wire [31:0] preset;

    wire enter_rise = enter_s && !enter_d1_q;
    wire rx_nmt = rx_valid_i && (rx_id_i == `CPP_ID_NMT) && (rx_dlc_i >= 4'h2);
    wire nmt_mine = (rx_data_i[15:8] == {3'h0, node_q}) ||
                    (rx_data_i[15:8] == `CPP_NMT_ALL);
    wire nmt_start = rx_nmt && nmt_mine && (rx_data_i[7:0] == `CPP_NMT_START);
    wire nmt_stop = rx_nmt && nmt_mine && (rx_data_i[7:0] == `CPP_NMT_STOP);
    wire rx_sync = rx_valid_i && (rx_id_i == `CPP_ID_SYNC);
    wire trig_async = enter_rise || soft_send_q;
    wire trigger = !ctrl_q[`CPP_CTRL_INHIBIT] &&
                   (sync_mode_q ? rx_sync : trig_async);

    cpp_bcd2bin u_conv (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .digits_i(thumb_s),
        .sign_mode_i(sign_mode_q),
        .value_o(preset)
    );

    // Enter edge history, read from the settled second stage.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            enter_d1_q <= 1'b0;
        end else begin
            enter_d1_q <= enter_s;
        end
    end

    // Straps are caught once, after the settle time following reset.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            init_cnt_q <= 32'h0;
            node_q <= 5'h0;
            sync_mode_q <= 1'b0;
            hi_bytes_q <= 1'b0;
            sign_mode_q <= 1'b0;
            rate_sel_q <= 3'h0;
            bitrate_kbps_o <= 11'h0;
        end else if (state_q == ST_INIT) begin
            init_cnt_q <= init_cnt_q + 32'h1;
            if (init_cnt_q == INIT_CYC[31:0]) begin
                node_q <= dip_addr_s[4:0];
                sync_mode_q <= dip_addr_s[5];
                hi_bytes_q <= dip_addr_s[6];
                sign_mode_q <= dip_rate_s[3];
                rate_sel_q <= dip_rate_s[2:0];
                bitrate_kbps_o <= rate_of(dip_rate_s[2:0]);
            end
        end
    end

    // Node state machine and frame assembly.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ST_INIT;
            tx_req_o <= 1'b0;
            tx_id_o <= 11'h0;
            tx_dlc_o <= 4'h0;
            tx_data_o <= 64'h0;
            tx_cnt_q <= 32'h0;
        end else begin
            case (state_q)
                ST_INIT: begin
                    if (init_cnt_q == INIT_CYC[31:0]) begin
                        state_q <= ST_PREOP;
                    end
                end
                ST_PREOP: begin
                    if (nmt_start) begin
                        state_q <= ST_OPER;
                    end
                end
                ST_OPER: begin
                    if (nmt_stop) begin
                        state_q <= ST_PREOP;
                    end else if (trigger) begin
                        state_q <= ST_SEND;
                        tx_req_o <= 1'b1;
                        tx_dlc_o <= `CPP_PDO_DLC;
                        tx_id_o <= (sync_mode_q ? `CPP_ID_PDO_SYNC : `CPP_ID_PDO_ASYNC)
                                   + {6'h0, node_q};
                        tx_data_o <= hi_bytes_q ? {preset, 32'h0}
                                                : {32'h0, preset};
                    end
                end
                ST_SEND: begin
                    // Triggers during a pending frame are dropped, not queued.
                    if (tx_ack_i) begin
                        tx_req_o <= 1'b0;
                        tx_cnt_q <= tx_cnt_q + 32'h1;
                        state_q <= nmt_stop ? ST_PREOP : ST_OPER;
                    end
                end
                default: begin
                    state_q <= ST_INIT;
                    tx_req_o <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error flags.

    // Error 1 never clears; error 2 clears on enter, but a set wins.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            err1_q <= 1'b0;
            err2_q <= 1'b0;
        end else begin
            if (err_fatal_i) begin
                err1_q <= 1'b1;
            end
            if (err_warn_i) begin
                err2_q <= 1'b1;
            end else if (enter_rise) begin
                err2_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Front LED.

    reg [31:0] led_cnt_q;
    reg [3:0] led_idx_q;

    // Step through a sixteen-slot pattern; error 1 outranks error 2.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            led_cnt_q <= 32'h0;
            led_idx_q <= 4'h0;
            led_o <= 1'b0;
        end else begin
            if (led_cnt_q >= LED_STEP_CYC[31:0] - 32'h1) begin
                led_cnt_q <= 32'h0;
                led_idx_q <= led_idx_q + 4'h1;
            end else begin
                led_cnt_q <= led_cnt_q + 32'h1;
            end
            if (err1_q) begin
                led_o <= LED_PAT_ERR1[led_idx_q];
            end else if (err2_q) begin
                led_o <= LED_PAT_ERR2[led_idx_q];
            end else begin
                led_o <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port.

    // Writes: inhibit bit persists, send bit is a one-cycle request.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q <= `CPP_CTRL_RST;
            soft_send_q <= 1'b0;
        end else begin
            soft_send_q <= 1'b0;
            if (reg_wr_i && reg_addr_i == `CPP_REG_CTRL) begin
                ctrl_q <= reg_wdata_i[1:0];
                soft_send_q <= reg_wdata_i[`CPP_CTRL_SEND];
            end
        end
    end

    // Reads answer one cycle later; unmapped offsets read zero.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 32'h0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `CPP_REG_CTRL: reg_rdata_o <= {30'h0, ctrl_q};
                `CPP_REG_STAT: reg_rdata_o <= {13'h0, rate_sel_q, sign_mode_q,
                    hi_bytes_q, sync_mode_q, node_q, 4'h0, tx_req_o,
                    (state_q == ST_OPER) || (state_q == ST_SEND), err2_q, err1_q};
                `CPP_REG_PRESET: reg_rdata_o <= preset;
                `CPP_REG_TXCNT: reg_rdata_o <= tx_cnt_q;
                default: reg_rdata_o <= 32'h0;
            endcase
        end else begin
            reg_rdata_o <= 32'h0;
        end
    end

endmodule

// ### sim/cpp_node_properties.sv
/* Checker for cpp_node: frame hold, identifiers, start gating, SYNC cause,
   read data, rate lock and LED. Assumes one clock and the node's port names. */
`timescale 1ns/100ps

module cpp_node_properties (
    // Node ports under watch.
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic rx_valid_i,
    input wire logic [10:0] rx_id_i,
    input wire logic [63:0] rx_data_i,
    input wire logic tx_req_o,
    input wire logic [10:0] tx_id_o,
    input wire logic [3:0] tx_dlc_o,
    input wire logic [63:0] tx_data_o,
    input wire logic tx_ack_i,
    input wire logic err_warn_i,
    input wire logic err_fatal_i,
    input wire logic [10:0] bitrate_kbps_o,
    input wire logic led_o,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic started_q;
    logic fault_q;
    logic fatal_q;

    // History since power-up; a cleared warning still counts in fault_q.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            started_q <= 1'b0;
            fault_q <= 1'b0;
            fatal_q <= 1'b0;
        end else begin
            started_q <= started_q |
                (rx_valid_i && rx_id_i == 11'h000 && rx_data_i[7:0] == 8'h01);
            fault_q <= fault_q | err_warn_i | err_fatal_i;
            fatal_q <= fatal_q | err_fatal_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_pdo_start; !tx_req_o ##1 tx_req_o; endsequence
    property p_hold;
        tx_req_o && !tx_ack_i |=> tx_req_o && $stable(tx_data_o) && $stable(tx_id_o);
    endproperty
    a_hold: assert property (p_hold) else $error("frame request dropped or changed");
    property p_frame;
        tx_req_o |-> tx_dlc_o == 4'h8 && tx_id_o[10:5] inside {6'h0c, 6'h14};
    endproperty
    a_frame: assert property (p_frame) else $error("bad pdo length or identifier");
    property p_sync_cause;
        s_pdo_start ##0 tx_id_o[10:5] == 6'h0c |-> $past(rx_valid_i && rx_id_i == 11'h080);
    endproperty
    a_sync_cause: assert property (p_sync_cause) else $error("sync pdo without sync");
    property p_start_gate; !started_q |-> !tx_req_o; endproperty
    a_start_gate: assert property (p_start_gate) else $error("pdo before start");
    property p_rdata_zero; !reg_rd_i |=> reg_rdata_o == 32'h0; endproperty
    a_rdata_zero: assert property (p_rdata_zero) else $error("read data without read");
    property p_rate_lock; bitrate_kbps_o != 11'd0 |=> $stable(bitrate_kbps_o); endproperty
    a_rate_lock: assert property (p_rate_lock) else $error("bit rate changed");
    // The sampled reset keeps the release edge out: the LED is still dark there.
    property p_led_steady;
        nrst_i && !fault_q && !err_warn_i && !err_fatal_i |=> led_o;
    endproperty
    a_led_steady: assert property (p_led_steady) else $error("led not steady");
    property p_err1_blink; fatal_q |-> ##[0:12] $changed(led_o); endproperty
    a_err1_blink: assert property (p_err1_blink) else $error("led not blinking on error 1");
endmodule

bind cpp_node cpp_node_properties i_cpp_node_properties (.clk_i, .nrst_i, .rx_valid_i,
    .rx_id_i, .rx_data_i, .tx_req_o, .tx_id_o, .tx_dlc_o, .tx_data_o, .tx_ack_i, .err_warn_i,
    .err_fatal_i, .bitrate_kbps_o, .led_o, .reg_rd_i, .reg_rdata_o);

// ### sim/cpp_can_model.sv
/* CAN side of the node: controller and master that send NMT and SYNC frames
   and acknowledge transmit requests. Assumes one clock shared with the node. */
`timescale 1ns/100ps

module cpp_can_model (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic nrst_i,
    // Transmit side of the node.
    input wire logic tx_req_i,
    input wire logic [10:0] tx_id_i,
    input wire logic [63:0] tx_data_i,
    output logic tx_ack_o,
    // Received frames towards the node.
    output logic rx_valid_o = 1'b0,
    output logic [10:0] rx_id_o = 11'h7ff,
    output logic [3:0] rx_dlc_o = 4'h0,
    output logic [63:0] rx_data_o = 64'h0
);
    int ack_dly = 0;
    int cnt;
    int sent;
    logic [10:0] last_id;
    logic [63:0] last_data;

    // Acknowledge after ack_dly idle cycles; a slow bus stretches the request.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_ack_o <= 1'b0;
            cnt <= 0;
            sent <= 0;
        end else begin
            tx_ack_o <= 1'b0;
            if (tx_req_i && !tx_ack_o && cnt >= ack_dly) begin
                tx_ack_o <= 1'b1;
                cnt <= 0;
                sent <= sent + 1;
                last_id <= tx_id_i;
                last_data <= tx_data_i;
            end else if (tx_req_i && !tx_ack_o) begin
                cnt <= cnt + 1;
            end
        end
    end

    // One received frame for one cycle; afterwards the lines show junk.
    task frame(input [10:0] id, input [3:0] dlc, input [63:0] d);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_id_o <= id;
        rx_dlc_o <= dlc;
        rx_data_o <= d;
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_id_o <= ~id;
        rx_data_o <= ~d;
    endtask

    // Network command from the master: command byte, then node byte.
    task nmt(input [7:0] cmd, input [7:0] node);
        frame(11'h000, 4'h2, {48'h0, node, cmd});
    endtask
endmodule

// ### sim/cpp_node_bench.sv
/* Bench for cpp_node: straps, start, async and sync PDOs, errors, registers.
   Assumes cpp_can_model and the bound checker are compiled first. */
`timescale 1ns/100ps
`include "cpp_defs.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    $display("[FAIL] %s exp %h got %h", nm, e, g); bad_count++; end end

module cpp_node_bench;
    // Pins, bus and counters.
    logic clk_i = 0;
    logic nrst_i = 0;
    logic [7:0] dip_addr_i = 8'h00;
    logic [3:0] dip_rate_i = 4'h0;
    logic [23:0] thumb_bcd_i = 24'h000000;
    logic enter_i = 0;
    logic err_warn_i = 0;
    logic err_fatal_i = 0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 0;
    logic reg_rd_i = 0;
    logic [31:0] rd;
    wire rx_valid_i, tx_req_o, tx_ack_i, led_o;
    wire [10:0] rx_id_i, tx_id_o, bitrate_kbps_o;
    wire [3:0] rx_dlc_i, tx_dlc_o;
    wire [63:0] rx_data_i, tx_data_o;
    wire [31:0] reg_rdata_o;
    int bad_count = 0;
    int comparisons = 0;
    int k;

    // 100 MHz clock.
    always #5 clk_i = ~clk_i;

    // Short power-up and LED step keep the run brief.
    cpp_node #(.INIT_CYC(8), .LED_STEP_CYC(4)) i_cpp_node (.clk_i, .nrst_i, .dip_addr_i,
        .dip_rate_i, .thumb_bcd_i, .enter_i, .rx_valid_i, .rx_id_i, .rx_dlc_i, .rx_data_i,
        .tx_req_o, .tx_id_o, .tx_dlc_o, .tx_data_o, .tx_ack_i, .err_warn_i, .err_fatal_i,
        .bitrate_kbps_o, .led_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);

    // Master and controller on the bus side.
    cpp_can_model i_cpp_can_model (.clk_i, .nrst_i, .tx_req_i(tx_req_o), .tx_id_i(tx_id_o),
        .tx_data_i(tx_data_o), .tx_ack_o(tx_ack_i), .rx_valid_o(rx_valid_i),
        .rx_id_o(rx_id_i), .rx_dlc_o(rx_dlc_i), .rx_data_o(rx_data_i));

    // Power cycle with new switch settings; reset held 10 cycles.
    task power(input [7:0] a, input [3:0] r);
        @(posedge clk_i);
        nrst_i <= 0;
        dip_addr_i <= a;
        dip_rate_i <= r;
        repeat (10) @(posedge clk_i);
        nrst_i <= 1;
        repeat (20) @(posedge clk_i);
    endtask

    // Enter held long enough to pass the input synchroniser.
    task press();
        @(posedge clk_i);
        enter_i <= 1;
        repeat (6) @(posedge clk_i);
        enter_i <= 0;
        repeat (12) @(posedge clk_i);
    endtask

    // Register cycles; read data is taken in the cycle after the strobe.
    task rreg(input [3:0] a);
        @(posedge clk_i);
        reg_rd_i <= 1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 0;
        #1 rd = reg_rdata_o;
    endtask
    task wreg(input [3:0] a, input [31:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 0;
    endtask

    // Bounded wait for the next sent frame.
    task wait_tx(input int was);
        for (k = 0; k < 60 && i_cpp_can_model.sent == was; k++) @(posedge clk_i);
    endtask

    // Node 5, async, high bytes, 125 kbit/s; then switches moved live.
    task t_async();
        i_cpp_can_model.ack_dly = 5;
        power(8'h45, 4'h3);
        dip_addr_i <= 8'h02;
        dip_rate_i <= 4'h6;
        thumb_bcd_i <= 24'h999999;
        `CHK("rate", 11'd125, bitrate_kbps_o)
        press();
        i_cpp_can_model.nmt(8'h01, 8'h07);
        press();
        `CHK("early pdo", 0, i_cpp_can_model.sent)
        i_cpp_can_model.nmt(8'h01, 8'h05);
        press();
        wait_tx(0);
        `CHK("async id", 11'h285, i_cpp_can_model.last_id)
        `CHK("async data", 64'h000f423f00000000, i_cpp_can_model.last_data)
        `CHK("rate held", 11'd125, bitrate_kbps_o)
        `CHK("led steady", 1'b1, led_o)
        wreg(`CPP_REG_CTRL, 32'h2);
        press();
        `CHK("inhibit", 1, i_cpp_can_model.sent)
        rreg(`CPP_REG_TXCNT);
        `CHK("count", 32'h1, rd)
        rreg(4'h2);
        `CHK("unmapped", 32'h0, rd)
        wreg(`CPP_REG_CTRL, 32'h1);
        wait_tx(1);
        `CHK("soft send", 2, i_cpp_can_model.sent)
        rreg(`CPP_REG_CTRL);
        `CHK("ctrl", 32'h1, rd)
    endtask

    // Node 31, sync, low bytes, sign on, 10 kbit/s; broadcast start.
    task t_sync();
        i_cpp_can_model.ack_dly = 0;
        power(8'h3f, 4'h8);
        thumb_bcd_i <= 24'h199999;
        `CHK("rate", 11'd10, bitrate_kbps_o)
        i_cpp_can_model.nmt(8'h01, 8'h00);
        press();
        `CHK("enter in sync", 0, i_cpp_can_model.sent)
        i_cpp_can_model.frame(11'h080, 4'h0, 64'h0);
        wait_tx(0);
        `CHK("sync id", 11'h19f, i_cpp_can_model.last_id)
        `CHK("sync data", 64'hfffe7961, i_cpp_can_model.last_data)
        i_cpp_can_model.frame(11'h080, 4'h0, 64'h0);
        wait_tx(1);
        `CHK("second sync", 2, i_cpp_can_model.sent)
        rreg(`CPP_REG_PRESET);
        `CHK("preset reg", 32'hfffe7961, rd)
        // A stop command sends the node back; a later SYNC must stay unanswered.
        i_cpp_can_model.nmt(8'h02, 8'h1f);
        i_cpp_can_model.frame(11'h080, 4'h0, 64'h0);
        wait_tx(2);
        `CHK("sync after stop", 2, i_cpp_can_model.sent)
        rreg(`CPP_REG_STAT);
        `CHK("stopped", 1'b0, rd[`CPP_STAT_OPER])
    endtask

    // Warning clears on enter; fatal error survives it.
    task t_err();
        @(posedge clk_i);
        err_warn_i <= 1;
        repeat (2) @(posedge clk_i);
        err_warn_i <= 0;
        rreg(`CPP_REG_STAT);
        `CHK("warn set", 1'b1, rd[`CPP_STAT_ERR2])
        press();
        rreg(`CPP_REG_STAT);
        `CHK("warn clear", 1'b0, rd[`CPP_STAT_ERR2])
        @(posedge clk_i);
        err_fatal_i <= 1;
        repeat (2) @(posedge clk_i);
        err_fatal_i <= 0;
        repeat (30) @(posedge clk_i);
        press();
        rreg(`CPP_REG_STAT);
        `CHK("fatal held", 1'b1, rd[`CPP_STAT_ERR1])
        `CHK("node", 5'h1f, rd[12:8])
        // The error 1 pattern alternates every step, so four cycles apart differ.
        k = led_o;
        repeat (4) @(posedge clk_i);
        #1 `CHK("led blink", ~k[0], led_o)
    endtask

    // Verdict and end of run.
    task test_done();
        if (bad_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence.
    initial begin
        t_async();
        t_sync();
        t_err();
        test_done();
    end

    // Watchdog well beyond the roughly 340 cycles the tests take.
    initial begin
        repeat (5000) @(posedge clk_i);
        bad_count++;
        test_done();
    end
endmodule
